//--- rtl/usr_defines.vh
`ifndef USR_DEFINES_VH
`define USR_DEFINES_VH

// ----------------------------------------------------------------
// Register geometry
// ----------------------------------------------------------------
`define USR_STAGES 4
`define USR_CLEAR 4'h0

// ----------------------------------------------------------------
// Mode codes, bit 1 is the upper select, bit 0 the lower select
// ----------------------------------------------------------------
`define USR_MODE_HOLD 2'h0
`define USR_MODE_SHR 2'h1
`define USR_MODE_SHL 2'h2
`define USR_MODE_LOAD 2'h3

// ----------------------------------------------------------------
// Layout of one captured edge word in the queue
// ----------------------------------------------------------------
`define USR_WORD_W 8
`define USR_F_PAR_LSB 0
`define USR_F_PAR_MSB 3
`define USR_F_SL 4
`define USR_F_SR 5
`define USR_F_MODE_LSB 6
`define USR_F_MODE_MSB 7

// ----------------------------------------------------------------
// Queue and synchroniser sizes
// ----------------------------------------------------------------
`define USR_FIFO_DEPTH 16
`define USR_FIFO_AW 4
`define USR_SYNC_W 9

`endif

//--- rtl/usr_sync.v
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Two flip-flop level synchroniser for a bundle of pins
// ----------------------------------------------------------------
module usr_sync #(
    parameter WIDTH = 9
) (
    input wire clk,                // System clock
    input wire sys_rst,            // Synchronous reset, active high
    input wire [WIDTH-1:0] d,      // Asynchronous pin levels
    output wire [WIDTH-1:0] q      // Levels after two stages
);

    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    // First stage feeds only the second, so metastability settles there
    always @(posedge clk) begin
        if (sys_rst) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;

endmodule

//--- rtl/usr_fifo.v
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Synchronous FIFO with registered full and empty flags
// ----------------------------------------------------------------
module usr_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,                // System clock
    input wire sys_rst,            // Synchronous flush, active high
    input wire in_valid,           // Write request
    output reg in_ready,           // Space available
    input wire [WIDTH-1:0] in_data,  // Write data
    output reg out_valid,          // Data available
    input wire out_ready,          // Read accept
    output wire [WIDTH-1:0] out_data // Head word
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    reg [AW:0] count_next;
    wire push;
    wire pop;

    // Handshakes use the registered flags so the source sees honest full
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ptr_reg];

    // Occupancy after this cycle
    always @* begin
        count_next = count_reg;
        if (push & ~pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop & ~push) begin
            count_next = count_reg - 1'b1;
        end
    end

    // Storage has no reset; only the pointers, count and flags need one
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers, count and flags
    always @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_next;
            in_ready <= (count_next != DEPTH[AW:0]);
            out_valid <= (count_next != {(AW+1){1'b0}});
        end
    end

endmodule

//--- rtl/usr_shift4.v
`timescale 1ns/1ps
`include "usr_defines.vh"

module usr_shift4 #(
    parameter STAGES = `USR_STAGES,
    parameter DEPTH = `USR_FIFO_DEPTH
) (
    input wire clk,                        // System clock, 100 MHz
    input wire sys_rst,                    // Synchronous reset, active high
    input wire master_reset_n,             // Asynchronous clear pin, active low
    input wire clock_pulse,                // Shift clock pin, rising edge acts
    input wire [1:0] mode_select,          // Mode pins, bit 1 upper, bit 0 lower
    input wire [STAGES-1:0] parallel_in,   // Parallel load pins
    input wire serial_in_left,             // Serial input at stage 3
    input wire serial_in_right,            // Serial input at stage 0
    input wire apply_stall,                // Freeze applying queued edges
    output reg [STAGES-1:0] parallel_out,  // Stored bits
    output wire capture_ready,             // Edge queue has room
    output reg edge_drop                   // Pulse: edge lost to a full queue
);

    // ----------------------------------------------------------------
    // Next-state function
    // ----------------------------------------------------------------

    // One edge's effect on the stored bits
    function [STAGES-1:0] usr_next;
        input [1:0] mode;
        input [STAGES-1:0] cur;
        input sl;
        input sr;
        input [STAGES-1:0] par;
        begin
            case (mode)
                `USR_MODE_HOLD: begin
                    usr_next = cur;
                end
                `USR_MODE_SHR: begin
                    usr_next = {cur[STAGES-2:0], sr};
                end
                `USR_MODE_SHL: begin
                    usr_next = {sl, cur[STAGES-1:1]};
                end
                `USR_MODE_LOAD: begin
                    usr_next = par;
                end
                default: begin
                    usr_next = cur;
                end
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Master reset: asserts at once, releases on the clock
    // ----------------------------------------------------------------
    reg rel_meta_reg;
    reg rel_sync_reg;

    // Release is synchronised so no flop sees a runt recovery window
    always @(posedge clk or negedge master_reset_n) begin
        if (!master_reset_n) begin
            rel_meta_reg <= 1'b0;
            rel_sync_reg <= 1'b0;
        end else begin
            rel_meta_reg <= 1'b1;
            rel_sync_reg <= rel_meta_reg;
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------------------------------
    wire [`USR_SYNC_W-1:0] pins_raw;
    wire [`USR_SYNC_W-1:0] pins_sync;
    wire pulse_sync;
    wire [`USR_WORD_W-1:0] edge_word;
    reg pulse_prev_reg;
    wire pulse_rise;
    reg [`USR_WORD_W-1:0] word_hold_reg;

    // Clock and data share one synchroniser so they stay aligned
    assign pins_raw = {clock_pulse, mode_select, serial_in_right, serial_in_left, parallel_in};
    assign pulse_sync = pins_sync[`USR_SYNC_W-1];

    usr_sync #(
        .WIDTH(`USR_SYNC_W)
    ) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(pins_raw),
        .q(pins_sync)
    );

    // Previous synchronised clock level; it follows the pin through a master
    // reset, so a pulse that rose while reset was low is not taken at release
    always @(posedge clk) begin
        if (sys_rst | ~rel_sync_reg) begin
            pulse_prev_reg <= pulse_sync;
            word_hold_reg <= {`USR_WORD_W{1'b0}};
        end else begin
            pulse_prev_reg <= pulse_sync;
            word_hold_reg <= pins_sync[`USR_WORD_W-1:0];
        end
    end

    // Data is the sample taken one system cycle before the edge is seen
    assign pulse_rise = pulse_sync & ~pulse_prev_reg & rel_sync_reg;
    assign edge_word = word_hold_reg;

    // ----------------------------------------------------------------
    // Edge queue
    // ----------------------------------------------------------------
    wire fifo_clr;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire [`USR_WORD_W-1:0] fifo_out_data;
    wire apply;

    // A held reset flushes edges captured before it, keeping inputs ignored
    assign fifo_clr = sys_rst | ~rel_sync_reg;
    assign fifo_out_ready = ~apply_stall & rel_sync_reg;
    assign apply = fifo_out_valid & fifo_out_ready;

    usr_fifo #(
        .WIDTH(`USR_WORD_W),
        .DEPTH(DEPTH),
        .AW(`USR_FIFO_AW)
    ) u_fifo (
        .clk(clk),
        .sys_rst(fifo_clr),
        .in_valid(pulse_rise),
        .in_ready(capture_ready),
        .in_data(edge_word),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Edges that meet a full queue are lost; the driving logic sees the pulse
    always @(posedge clk) begin
        if (sys_rst | ~rel_sync_reg) begin
            edge_drop <= 1'b0;
        end else begin
            edge_drop <= pulse_rise & ~capture_ready;
        end
    end

    // ----------------------------------------------------------------
    // Stored stages
    // ----------------------------------------------------------------

    // Async clear gives the immediate low; queued edges apply in order
    always @(posedge clk or negedge master_reset_n) begin
        if (!master_reset_n) begin
            parallel_out <= `USR_CLEAR;
        end else if (sys_rst) begin
            parallel_out <= `USR_CLEAR;
        end else if (apply) begin
            parallel_out <= usr_next(
                fifo_out_data[`USR_F_MODE_MSB:`USR_F_MODE_LSB],
                parallel_out,
                fifo_out_data[`USR_F_SL],
                fifo_out_data[`USR_F_SR],
                fifo_out_data[`USR_F_PAR_MSB:`USR_F_PAR_LSB]);
        end
    end

endmodule

//--- tb/usr_shift4_asserts.sv
`timescale 1ns/1ps
// ----
// Port checker
// ----
module usr_chk (
    input wire clk, // System clock
    input wire sys_rst, // Sync reset
    input wire master_reset_n, // Async clear, low
    input wire clock_pulse, // Shift clock pin
    input wire [1:0] mode_select, // Mode pins
    input wire [3:0] parallel_in, // Load pins
    input wire serial_in_left, // Left serial pin
    input wire serial_in_right, // Right serial pin
    input wire apply_stall, // Queue freeze
    input wire [3:0] parallel_out, // Stored bits
    input wire capture_ready, // Queue room
    input wire edge_drop // Lost edge pulse
);
    reg [3:0] want_reg = 4'h0;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst || !master_reset_n);
    // Next state from the pins as the edge is first seen; valid only with an idle queue
    always @(posedge clk) begin
        if ($rose(clock_pulse)) begin
            case (mode_select)
                2'h0: want_reg <= parallel_out;
                2'h1: want_reg <= {parallel_out[2:0], serial_in_right};
                2'h2: want_reg <= {serial_in_left, parallel_out[3:1]};
                default: want_reg <= parallel_in;
            endcase
        end
    end
    a_async_clear: assert property (disable iff (sys_rst)
        !master_reset_n |-> parallel_out == 4'h0) else $error("not cleared by master reset");
    a_sync_clear: assert property (disable iff (1'b0)
        sys_rst |=> parallel_out == 4'h0 && !capture_ready && !edge_drop) else $error("bad reset");
    a_hold_keep: assert property (
        $rose(clock_pulse) && mode_select == 2'h0 |=> $stable(parallel_out)[*8]) else $error("hold");
    a_load_copy: assert property (
        $rose(clock_pulse) && mode_select == 2'h3 && !apply_stall
        |=> ##[1:7] parallel_out == want_reg) else $error("load");
    a_left_shift: assert property (
        $rose(clock_pulse) && mode_select == 2'h2 && !apply_stall
        |=> ##[1:7] parallel_out == want_reg) else $error("shift left");
    a_right_shift: assert property (
        $rose(clock_pulse) && mode_select == 2'h1 && !apply_stall
        |=> ##[1:7] parallel_out == want_reg) else $error("shift right");
    a_stall_freeze: assert property (
        $past(apply_stall) && !$past(sys_rst) && $past(master_reset_n)
        |-> $stable(parallel_out)) else $error("changed while stalled");
    a_drop_full: assert property (
        edge_drop |-> !$past(capture_ready) ##1 !edge_drop) else $error("bad drop pulse");
endmodule

bind usr_shift4 usr_chk u_chk (.clk(clk), .sys_rst(sys_rst), .master_reset_n(master_reset_n),
    .clock_pulse(clock_pulse), .mode_select(mode_select), .parallel_in(parallel_in),
    .serial_in_left(serial_in_left), .serial_in_right(serial_in_right),
    .apply_stall(apply_stall), .parallel_out(parallel_out), .capture_ready(capture_ready),
    .edge_drop(edge_drop));

//--- tb/usr_drv.sv
`timescale 1ns/1ps
// ----
// Pin driver for one shift clock edge
// ----
module usr_drv (
    input wire clk, // System clock
    input wire go, // Start one edge
    input wire [1:0] mode, // Mode wanted
    input wire [3:0] par, // Load data
    input wire sl, // Left serial bit
    input wire sr, // Right serial bit
    output reg clock_pulse = 1'b0, // Shift clock pin
    output reg [1:0] mode_select = 2'h0, // Mode pins
    output reg [3:0] parallel_in = 4'h0, // Load pins
    output reg serial_in_left = 1'b0, // Left serial pin
    output reg serial_in_right = 1'b0, // Right serial pin
    output reg busy = 1'b0 // Edge in progress
);
    reg [2:0] cnt_reg = 3'h0;
    // Pins lead the rise by two clocks and trail it by six
    always @(posedge clk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            cnt_reg <= 3'h0;
            mode_select <= mode;
            parallel_in <= par;
            serial_in_left <= sl;
            serial_in_right <= sr;
        end else if (busy) begin
            cnt_reg <= cnt_reg + 3'h1;
            if (cnt_reg == 3'h1) clock_pulse <= 1'b1;
            if (cnt_reg == 3'h4) clock_pulse <= 1'b0;
            if (cnt_reg == 3'h7) begin
                // Hold over: flip pins so stale values never pass for good ones
                busy <= 1'b0;
                {mode_select, parallel_in, serial_in_left, serial_in_right} <=
                    ~{mode_select, parallel_in, serial_in_left, serial_in_right};
            end
        end
    end
endmodule

//--- tb/usr_shift4_tb.sv
`timescale 1ns/1ps
module usr_shift4_tb;
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg master_reset_n = 1'b1;
    reg apply_stall = 1'b0;
    reg go = 1'b0;
    reg [1:0] mode = 2'h0;
    reg [3:0] par = 4'h0;
    reg sl = 1'b0;
    reg sr = 1'b0;
    reg drop_seen = 1'b0;
    wire clock_pulse, serial_in_left, serial_in_right, capture_ready, edge_drop, busy;
    wire [1:0] mode_select;
    wire [3:0] parallel_in, parallel_out;
    integer mismatches = 0;
    integer tests_run = 0;
    integer i;
    initial forever #5 clk = ~clk;
    // Remember any lost-edge pulse
    always @(posedge clk) if (edge_drop === 1'b1) drop_seen <= 1'b1;
    usr_shift4 DUT (.clk(clk), .sys_rst(sys_rst), .master_reset_n(master_reset_n),
        .clock_pulse(clock_pulse), .mode_select(mode_select), .parallel_in(parallel_in),
        .serial_in_left(serial_in_left), .serial_in_right(serial_in_right),
        .apply_stall(apply_stall), .parallel_out(parallel_out),
        .capture_ready(capture_ready), .edge_drop(edge_drop));
    usr_drv u_drv (.clk(clk), .go(go), .mode(mode), .par(par), .sl(sl), .sr(sr),
        .clock_pulse(clock_pulse), .mode_select(mode_select), .parallel_in(parallel_in),
        .serial_in_left(serial_in_left), .serial_in_right(serial_in_right), .busy(busy));
    task check(input [3:0] seen, input [3:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task conclude;
        begin
            $display("checks %0d mismatches %0d", tests_run, mismatches);
            if (mismatches == 0 && tests_run > 0)
                $display("STATUS OK");
            else
                $display("STATUS NOT OK");
            $finish;
        end
    endtask
    // One edge through the driver; bounded wait, then margin for the queue
    task do_edge(input [1:0] m, input [3:0] p, input l, input r);
        integer n;
        begin
            mode <= m;
            par <= p;
            sl <= l;
            sr <= r;
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            n = 0;
            @(posedge clk);
            while (busy !== 1'b0 && n < 40) begin
                @(posedge clk);
                n = n + 1;
            end
            if (n == 40) begin
                mismatches = mismatches + 1;
                conclude;
            end
            repeat (3) @(posedge clk);
        end
    endtask
    task t_modes;
        begin
            do_edge(2'h3, 4'hA, 1'b0, 1'b0);
            check(parallel_out, 4'hA);
            do_edge(2'h3, 4'h5, 1'b1, 1'b1);
            check(parallel_out, 4'h5);
            do_edge(2'h0, 4'hF, 1'b1, 1'b1);
            check(parallel_out, 4'h5);
            do_edge(2'h2, 4'h0, 1'b1, 1'b0);
            check(parallel_out, 4'hA);
            do_edge(2'h2, 4'hF, 1'b0, 1'b1);
            check(parallel_out, 4'h5);
            do_edge(2'h1, 4'h0, 1'b0, 1'b1);
            check(parallel_out, 4'hB);
            do_edge(2'h1, 4'hF, 1'b1, 1'b0);
            check(parallel_out, 4'h6);
            $display("modes done");
        end
    endtask
    task t_mreset;
        begin
            master_reset_n <= 1'b0;
            #1;
            check(parallel_out, 4'h0);
            do_edge(2'h3, 4'hF, 1'b1, 1'b1);
            check(parallel_out, 4'h0);
            master_reset_n <= 1'b1;
            repeat (4) @(posedge clk);
            do_edge(2'h3, 4'h9, 1'b0, 1'b0);
            check(parallel_out, 4'h9);
            $display("master reset done");
        end
    endtask
    task t_fill;
        begin
            apply_stall <= 1'b1;
            for (i = 0; i < 16; i = i + 1) do_edge(2'h3, i[3:0], 1'b0, 1'b0);
            check({3'h0, capture_ready}, 4'h0);
            check(parallel_out, 4'h9);
            do_edge(2'h3, 4'h9, 1'b0, 1'b0);
            check({3'h0, drop_seen}, 4'h1);
            apply_stall <= 1'b0;
            repeat (24) @(posedge clk);
            check(parallel_out, 4'hF);
            check({3'h0, capture_ready}, 4'h1);
            $display("fill done");
        end
    endtask
    task t_reset;
        begin
            repeat (8) @(posedge clk);
            sys_rst <= 1'b0;
            repeat (4) @(posedge clk);
            check(parallel_out, 4'h0);
            check({3'h0, capture_ready}, 4'h1);
            $display("reset done");
        end
    endtask
    initial begin
        t_reset;
        t_modes;
        t_mreset;
        t_fill;
        conclude;
    end
endmodule
